//--- hdl/udbc_pkg.sv
/*
 * Shared constants for the up/down binary counter: register offsets,
 * field positions and reset values.
 * Assumes a 32-bit AXI4-Lite register bus with a 4-bit byte address.
 */
package udbc_pkg;

    localparam int unsigned CNT_W = 4;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;

    // byte offsets of the registers
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PRESET = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

    // control register fields
    localparam int unsigned CTRL_DIR_BIT = 0;
    localparam int unsigned CTRL_GATE_N_BIT = 1;
    localparam int unsigned CTRL_LOAD_BIT = 2;
    localparam int unsigned CTRL_CLEAR_BIT = 3;
    localparam int unsigned CTRL_W = 4;
    // count up, gate closed, no load, no clear
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h3;

    // status register fields
    localparam int unsigned STAT_CNT_LSB = 0;
    localparam int unsigned STAT_TFLAG_BIT = 4;

    localparam logic [CNT_W-1:0] PRESET_RESET = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ALL_ONES = 4'hf;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : udbc_pkg

//--- hdl/udbc_core.sv
/*
 * Four-bit up/down binary counter core with level preset and clear.
 * Assumes every input is synchronous to clk_i; the count clock is a
 * plain input whose rising edges are detected against clk_i.
 */
`timescale 1ns/1ps
module udbc_core
    import udbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic count_clock_i,
    input wire logic count_gate_n_i,
    input wire logic direction_select_i,
    input wire logic async_preset_load_i,
    input wire logic [udbc_pkg::CNT_W-1:0] preset_inputs_i,
    input wire logic clear_all_i,
    output logic [udbc_pkg::CNT_W-1:0] count_value_o,
    output logic terminal_flag_n_o
);
    import udbc_pkg::*;

    logic clock_prev_q;
    logic clock_rise;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            clock_prev_q <= 1'b0;
        else
            clock_prev_q <= count_clock_i;
    end

    assign clock_rise = count_clock_i & ~clock_prev_q;

    always_comb
    begin
        count_d = count_q;
        if (clear_all_i)
            count_d = CNT_RESET;
        else if (async_preset_load_i)
            count_d = preset_inputs_i;
        else if (!count_gate_n_i && clock_rise)
        begin
            // plain 4-bit arithmetic wraps both ways
            if (direction_select_i)
                count_d = count_q + 4'h1;
            else
                count_d = count_q - 4'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_q <= CNT_RESET;
        else
            count_q <= count_d;
    end

    assign count_value_o = count_q;

    // flag follows the gate at once, not the next count edge
    always_comb
    begin
        terminal_flag_n_o = 1'b1;
        if (!count_gate_n_i)
        begin
            if (direction_select_i)
                terminal_flag_n_o = ~(count_q == CNT_ALL_ONES);
            else
                terminal_flag_n_o = ~(count_q == CNT_RESET);
        end
    end

endmodule : udbc_core

//--- hdl/udbc_top.sv
/*
 * Up/down binary counter with an AXI4-Lite register slave.
 * Assumes a single clock, a synchronous active-high reset, a count clock
 * input synchronous to clk_i and one outstanding access per direction.
 * Protection bits are ignored; only byte lane 0 of a write counts.
 */
`timescale 1ns/1ps
module udbc_top
    import udbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic count_clock_i,
    output logic [udbc_pkg::CNT_W-1:0] count_value_o,
    output logic terminal_flag_n_o,
    input wire logic [udbc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [udbc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [udbc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [udbc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import udbc_pkg::*;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        is_mapped = (addr == OFS_CTRL) || (addr == OFS_PRESET)
            || (addr == OFS_STATUS);
    endfunction : is_mapped

    logic [CTRL_W-1:0] ctrl_q;
    logic [CNT_W-1:0] preset_q;

    logic aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_held_q;
    logic [DATA_W-1:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [DATA_W-1:0] rdata_q;

    logic aw_take;
    logic w_take;
    logic do_write;
    logic ar_take;
    logic [DATA_W-1:0] rd_word;
    logic wr_ctrl;
    logic wr_preset;

    // address and data may arrive in either order; each is held until
    // the other shows up, and neither is taken while a response waits
    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    // the write fires once both halves are held, one edge after the
    // later of the two is taken
    assign do_write = aw_held_q & w_held_q;

    // addresses are kept whole so an unmapped one still gets its error
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end
        else if (aw_take)
        begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end
        else if (w_take)
        begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
        else if (do_write)
            w_held_q <= 1'b0;
    end

    // every field lives in byte lane 0, so only wstrb[0] matters
    assign wr_ctrl = do_write && w_strb_q[0] && (aw_addr_q == OFS_CTRL);
    assign wr_preset = do_write && w_strb_q[0]
        && (aw_addr_q == OFS_PRESET);

    // a write with lane 0 off is answered but changes nothing
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_q <= CTRL_RESET;
        else if (wr_ctrl)
            ctrl_q <= w_data_q[CTRL_W-1:0];
    end

    // preset reaches the count only while load is set in ctrl
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            preset_q <= PRESET_RESET;
        else if (wr_preset)
            preset_q <= w_data_q[CNT_W-1:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_DECERR;
        end
        // the answer stands until bready; no write is taken meanwhile
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // read side: one read at a time; data are captured when the address
    // is taken, so a later count step cannot tear the word
    assign s_axi_arready = ~rvalid_q;
    assign ar_take = s_axi_arvalid & s_axi_arready;

    // unmapped addresses read as zero and are answered with an error
    always_comb
    begin
        rd_word = '0;
        unique case (s_axi_araddr)
            OFS_CTRL:
                rd_word[CTRL_W-1:0] = ctrl_q;
            OFS_PRESET:
                rd_word[CNT_W-1:0] = preset_q;
            OFS_STATUS:
            begin
                rd_word[STAT_CNT_LSB +: CNT_W] = count_value_o;
                rd_word[STAT_TFLAG_BIT] = terminal_flag_n_o;
            end
            default:
                rd_word = '0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end
        else if (ar_take)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
            rdata_q <= rd_word;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // clear and load are levels held in ctrl; they act every cycle
    // and reach the count one edge after the write lands, no later
    // than the write answer is taken, so a following read sees them
    udbc_core udbc_core_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .count_clock_i(count_clock_i),
        .count_gate_n_i(ctrl_q[CTRL_GATE_N_BIT]),
        .direction_select_i(ctrl_q[CTRL_DIR_BIT]),
        .async_preset_load_i(ctrl_q[CTRL_LOAD_BIT]),
        .preset_inputs_i(preset_q),
        .clear_all_i(ctrl_q[CTRL_CLEAR_BIT]),
        .count_value_o(count_value_o),
        .terminal_flag_n_o(terminal_flag_n_o)
    );

endmodule : udbc_top

//--- dv/udbc_props.sv
/* Port checker for the counter top.
   Assumes one clock and a synchronous high reset. */
`timescale 1ns/1ps
module udbc_props
    import udbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic count_clock_i,
    input wire logic [udbc_pkg::CNT_W-1:0] count_value_o,
    input wire logic terminal_flag_n_o,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [udbc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_rresp
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    bv_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer stuck");
    rv_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer stuck");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    rd_decerr_a: assert property (rd_taken and s_axi_araddr == 4'hc
        |=> s_axi_rresp == RESP_DECERR) else $error("unmapped read okay");
    flag_state_a: assert property (!terminal_flag_n_o |->
        count_value_o == 4'h0 || count_value_o == 4'hf)
        else $error("flag low at middle count");
    // bus writes may load or clear, so only quiet periods are judged
    step_only_a: assert property ($changed(count_value_o)
        && !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)
        |-> $past(count_clock_i) && !$past(count_clock_i, 2)
        && (count_value_o == $past(count_value_o) + 4'h1
        || count_value_o == $past(count_value_o) - 4'h1))
        else $error("count moved without a clock step");
endmodule : udbc_props
bind udbc_top udbc_props udbc_props_inst (.*);

//--- dv/udbc_board.sv
/* Board logic making count clock pulses on request.
   Assumes req_i is driven synchronous to clk_i. */
`timescale 1ns/1ps
module udbc_board #(parameter int HOLD = 2)
(
    input wire logic clk_i,
    input wire logic req_i,
    output logic count_clock_o
);
    int n_q = 0;
    always_ff @(posedge clk_i)
    begin
        if (req_i)
            n_q <= HOLD;
        else if (n_q > 0)
            n_q <= n_q - 1;
    end
    assign count_clock_o = (n_q > 0);
endmodule : udbc_board

//--- dv/udbc_top_tb.sv
/* Register-level bench for the counter top.
   Assumes the board model drives the count clock. */
`timescale 1ns/1ps
module udbc_top_tb;
    import udbc_pkg::*;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic req = 1'h0;
    logic count_clock_i, terminal_flag_n_o;
    logic [CNT_W-1:0] count_value_o;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, data;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int fail_count = 0;
    int cmp_count = 0;
    udbc_top udbc_top_inst (.*);
    udbc_board udbc_board_inst (.clk_i(clk_i), .req_i(req),
        .count_clock_o(count_clock_i));
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic finish_test;
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask : chk_resp
    task automatic hang(input int n);
        if (n == 50)
        begin
            fail_count++;
            finish_test();
        end
    endtask : hang
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        hang(n);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        int n;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        hang(n);
    endtask : rd
    task automatic st(input logic [31:0] exp);
        rd(OFS_STATUS);
        chk(data, exp);
        chk({27'h0, terminal_flag_n_o, count_value_o}, exp);
    endtask : st
    // high for two cycles, then low long enough to be seen again
    task automatic pulse;
        @(posedge clk_i);
        req <= 1'h1;
        @(posedge clk_i);
        req <= 1'h0;
        repeat (5) @(posedge clk_i);
    endtask : pulse
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(OFS_CTRL);
        chk(data, 32'h3);
        st(32'h10);
        wr(OFS_PRESET, 32'he);
        wr(OFS_CTRL, 32'h5);
        pulse();
        st(32'h1e);
        wr(OFS_CTRL, 32'h1);
        pulse();
        st(32'h0f);
        pulse();
        st(32'h10);
        wr(OFS_CTRL, 32'h0);
        st(32'h00);
        pulse();
        st(32'h1f);
        wr(OFS_CTRL, 32'h2);
        pulse();
        st(32'h1f);
        wr(OFS_CTRL, 32'hd);
        pulse();
        st(32'h10);
        s_axi_wstrb <= 4'h0;
        wr(OFS_CTRL, 32'h2);
        s_axi_wstrb <= 4'hf;
        chk_resp(resp, RESP_OKAY);
        rd(OFS_CTRL);
        chk(data, 32'hd);
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(OFS_CTRL);
        chk(data, 32'h3);
        st(32'h10);
        wr(4'hc, 32'h0);
        chk_resp(resp, RESP_DECERR);
        wr(OFS_STATUS, 32'h0);
        chk_resp(resp, RESP_OKAY);
        rd(4'hc);
        chk_resp(resp, RESP_DECERR);
        finish_test();
    end
endmodule : udbc_top_tb
